// ---- macrocell_logic_array_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module macrocell_logic_array_tb
  import mla_pkg::*;
;
  typedef struct packed {
    logic [31:0] cfg;
    logic [7:0]  pins;
    logic [7:0]  out;
    logic [7:0]  oe;
  } mla_row_t;
  // Rows: control word, input pins, expected pin levels and enables.
  localparam mla_row_t ROWS [5] = '{
    '{32'h0001_FF00, 8'hA5, 8'hA5, 8'hFF},
    '{32'h0001_0000, 8'hA5, 8'h5A, 8'hFF},
    '{32'h0001_00FF, 8'h3C, 8'h00, 8'h00},
    '{32'h0003_FFFF, 8'h3C, 8'h3C, 8'h3C},
    '{32'h0002_FFFF, 8'hC3, 8'hC3, 8'hC3}
  };
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wdata    = 32'h0000_0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        pin_clk  = 1'b0;
  logic        outs_on  = 1'b1;
  logic [7:0]  pins     = 8'h00;
  logic [7:0]  board_io = 8'h5A;
  logic [31:0] rdata;
  logic        pin_oe_n;
  logic [7:0]  io_wire;
  logic [7:0]  io_out;
  logic [7:0]  io_oe;
  int          err_total = 0;
  int          compares  = 0;
  // Free-running system clock.
  always #2.5 clock_in = ~clock_in;
  mla_array i_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pin_clk_in(pin_clk),
    .pin_oe_n_in(pin_oe_n), .pin_input_in(pins), .io_in(io_wire), .io_out(io_out),
    .io_oe_out(io_oe)
  );
  mla_board i_board (
    .outs_on_in(outs_on), .board_io_in(board_io), .io_out_in(io_out), .io_oe_in(io_oe),
    .pin_oe_n_out(pin_oe_n), .io_wire_out(io_wire)
  );
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The write strobe stays up across back-to-back writes to avoid a double assignment.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    rd    <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clock_in);
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    addr <= a;
    wr   <= 1'b0;
    rd   <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
    @(posedge clock_in);
  endtask
  // Configuration changes only inside program mode, as when a part is reprogrammed.
  task automatic set_cfg(input logic [31:0] cfg);
    bus_wr(OFS_CTRL, 32'h0000_0001);
    bus_wr(OFS_CONFIG, cfg);
    bus_wr(OFS_CTRL, 32'h0000_0000);
    idle(20);
  endtask
  task automatic pulse();
    pin_clk <= 1'b1;
    idle(10);
    pin_clk <= 1'b0;
    idle(20);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The run needs about five hundred cycles; this cuts a hang short.
  initial begin
    #50us;
    err_total++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    // Reset values and refused accesses.
    rd_chk(OFS_CONFIG, CONFIG_RESET, "config reset");
    rd_chk(OFS_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(OFS_TERM_BASE, TERM_RESET, "term reset");
    rd_chk(8'h20, 32'h0000_0000, "unmapped");
    bus_wr(OFS_CONFIG, 32'h0002_0000);
    rd_chk(OFS_CONFIG, CONFIG_RESET, "config locked");
    check("oe after reset", 32'(io_oe), 32'h0000_0000);
    $display("reset test done");
    // Terms 0 and 1 of each cell take its own input; the rest join true and complement.
    bus_wr(OFS_CTRL, 32'h0000_0001);
    for (int k = 0; k < 64; k++) begin
      bus_wr(OFS_TERM_BASE + 8'(k), (k % 8 < 2) ? 32'h0000_0001 << (k / 8) : 32'h0001_0001);
    end
    rd_chk(8'h49, 32'h0000_0002, "term readback");
    set_cfg(32'hFFFF_FFFF);
    rd_chk(OFS_CONFIG, 32'h0003_FFFF, "config width");
    for (int i = 0; i < 5; i++) begin
      set_cfg(ROWS[i].cfg);
      rd_chk(OFS_CONFIG, ROWS[i].cfg, "config");
      pins <= ROWS[i].pins;
      idle(20);
      check("io_oe", 32'(io_oe), 32'(ROWS[i].oe));
      check("io_out", 32'(io_out & ROWS[i].oe), 32'(ROWS[i].out));
      $display("row %0d done", i);
    end
    // Cell 2 reads the feedback of input cell 1, which carries pin 0.
    bus_wr(OFS_CTRL, 32'h0000_0001);
    bus_wr(OFS_TERM_BASE + 8'h10, 32'h0000_0200);
    bus_wr(OFS_TERM_BASE + 8'h11, 32'h0000_0200);
    set_cfg(32'h0001_FF02);
    for (int v = 0; v < 2; v++) begin
      pins <= 8'(v);
      idle(20);
      check("adjacent", 32'(io_out[2]), 32'(v));
    end
    check("input cell oe", 32'(io_oe[1]), 32'h0000_0000);
    rd_chk(OFS_PINS, 32'h0000_0107, "pins view");
    $display("feedback test done");
    // Registered cells: high after clear, load on clock pin rise, cell 2 shifts cell 1.
    pins <= 8'h00;
    set_cfg(32'h0002_FF00);
    check("reg clear", 32'(io_out), 32'h0000_00FF);
    check("reg oe", 32'(io_oe), 32'h0000_00FF);
    pulse();
    check("reg load", 32'(io_out), 32'h0000_0004);
    rd_chk(OFS_CELLS, 32'h0004_FFFB, "cells view");
    pulse();
    check("reg feedback", 32'(io_out), 32'h0000_0000);
    outs_on <= 1'b0;
    idle(10);
    check("oe pin off", 32'(io_oe), 32'h0000_0000);
    $display("register test done");
    // Reset in mid-run.
    rst_n_in <= 1'b0;
    idle(2);
    check("reset io", {16'h0000, io_oe, io_out}, 32'h0000_0000);
    rst_n_in <= 1'b1;
    idle(20);
    rd_chk(OFS_CONFIG, CONFIG_RESET, "config again");
    $display("second reset test done");
    test_done();
  end
endmodule // macrocell_logic_array_tb
`default_nettype wire

// ---- mla_array.sv ----
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module mla_array
  import mla_pkg::*;
(
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  input  wire logic [ADDR_W-1:0]     reg_addr_in,
  input  wire logic [DATA_W-1:0]     reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [DATA_W-1:0]     reg_rdata_out,
  input  wire logic                  pin_clk_in,
  input  wire logic                  pin_oe_n_in,
  input  wire logic [NUM_INPUTS-1:0] pin_input_in,
  input  wire logic [NUM_CELLS-1:0]  io_in,
  output logic      [NUM_CELLS-1:0]  io_out,
  output logic      [NUM_CELLS-1:0]  io_oe_out
);
  localparam int NUM_PTS = NUM_CELLS * NUM_TERMS;

  // A term is high unless some connected column is low. With nothing
  // connected it stays high; with both forms of one signal it goes low.
  function automatic logic term_eval(input logic [NUM_COLS-1:0] fuses,
                                     input logic [NUM_COLS-1:0] cols);
    term_eval = &(~fuses | cols);
  endfunction

  // Address match helper for the register port.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Pin synchronisers: the first stage feeds only the second.
  logic [NUM_INPUTS-1:0] in_meta;
  logic [NUM_INPUTS-1:0] in_sync;
  logic [NUM_CELLS-1:0]  io_meta;
  logic [NUM_CELLS-1:0]  io_sync;
  logic                  clk_meta;
  logic                  clk_sync;
  logic                  clk_prev;
  logic                  oe_meta;
  logic                  oe_sync;

  // Register state.
  logic                  prog_mode;
  logic [DATA_W-1:0]     config_word;
  logic [DATA_W-1:0]     term_fuses [NUM_PTS];

  // Decoded configuration fields.
  logic [NUM_CELLS-1:0]  cell_config_local;
  logic [NUM_CELLS-1:0]  polarity_local;
  logic                  register_allow_global;
  logic                  emulation_select_global;

  // Array signals.
  logic [NUM_CELLS-1:0]  feedback;
  logic [NUM_CELLS-1:0]  adjacent_pin;
  logic [NUM_CELLS-1:0]  cell_data;
  logic [NUM_CELLS-1:0]  cell_enable;
  logic [NUM_CELLS-1:0]  cell_state;
  logic [NUM_COLS-1:0]   columns;
  logic [NUM_PTS-1:0]    terms;
  logic                  clk_rise;

  // Bus decode.
  logic                  hit_ctrl;
  logic                  hit_config;
  logic                  hit_pins;
  logic                  hit_cells;
  logic                  hit_term;
  logic [5:0]            term_index;
  logic                  wr_ctrl;
  logic                  wr_config;
  logic                  wr_term;
  logic [DATA_W-1:0]     ctrl_view;
  logic [DATA_W-1:0]     pins_view;
  logic [DATA_W-1:0]     cells_view;
  logic [DATA_W-1:0]     read_value;

  // Two flops on every pin input; the clock pin gets a third for edges.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_meta  <= '0;
      in_sync  <= '0;
      io_meta  <= '0;
      io_sync  <= '0;
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      oe_meta  <= 1'b1;
      oe_sync  <= 1'b1;
    end else begin
      in_meta  <= pin_input_in;
      in_sync  <= in_meta;
      io_meta  <= io_in;
      io_sync  <= io_meta;
      clk_meta <= pin_clk_in;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      oe_meta  <= pin_oe_n_in;
      oe_sync  <= oe_meta;
    end
  end

  // The clock pin becomes a one-cycle enable on its rising edge. It only
  // matters to registered cells, so as an array input it costs nothing.
  // clock pin edge
  assign clk_rise = clk_sync & ~clk_prev;

  // Configuration fields.
  // control word fields
  assign cell_config_local       = config_word[CFG_LOCAL_LSB +: NUM_CELLS];
  assign polarity_local          = config_word[CFG_POL_LSB +: NUM_CELLS];
  assign register_allow_global   = config_word[CFG_ALLOW_BIT];
  assign emulation_select_global = config_word[CFG_EMUL_BIT];

  // Array columns: true forms in the low half, complements in the high.
  // complementary columns
  assign columns = {~feedback, ~in_sync, feedback, in_sync};

  // Adjacent pin for dedicated inputs. Edge cells take the enable and
  // clock pins; the two middle pins are never picked up by a neighbour.
  // adjacent pins
  assign adjacent_pin[0] = oe_sync;
  assign adjacent_pin[1] = io_sync[0];
  assign adjacent_pin[2] = io_sync[1];
  assign adjacent_pin[3] = io_sync[2];
  assign adjacent_pin[4] = io_sync[5];
  assign adjacent_pin[5] = io_sync[6];
  assign adjacent_pin[6] = io_sync[7];
  assign adjacent_pin[7] = clk_sync;

  // Programmable AND array.
  // AND array
  genvar t;
  generate
    for (t = 0; t < NUM_PTS; t++) begin : g_term
      assign terms[t] = term_eval(term_fuses[t], columns);
    end
  endgenerate

  // Eight macrocells, the outer two with the altered feedback control.
  // macrocells
  genvar c;
  generate
    for (c = 0; c < NUM_CELLS; c++) begin : g_cell
      mla_cell #(
        .EDGE_CELL ((c == 0) || (c == NUM_CELLS - 1))
      ) u_cell (
        .clock_in                   (clock_in),
        .rst_n_in                   (rst_n_in),
        .clear_in                   (prog_mode),
        .clk_rise_in                (clk_rise),
        .term_in                    (terms[c*NUM_TERMS +: NUM_TERMS]),
        .register_allow_global_in   (register_allow_global),
        .emulation_select_global_in (emulation_select_global),
        .cell_config_local_in       (cell_config_local[c]),
        .polarity_local_in          (polarity_local[c]),
        .oe_pin_n_in                (oe_sync),
        .io_pin_in                  (io_sync[c]),
        .adjacent_pin_in            (adjacent_pin[c]),
        .feedback_out               (feedback[c]),
        .data_out                   (cell_data[c]),
        .enable_out                 (cell_enable[c]),
        .state_out                  (cell_state[c])
      );
    end
  endgenerate

  // Pin drivers are flopped. While reprogramming, every buffer is off so
  // a half-written pattern never reaches the board.
  // outputs quiet while programming
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_out    <= '0;
      io_oe_out <= '0;
    end else begin
      io_out    <= cell_data;
      io_oe_out <= prog_mode ? '0 : cell_enable;
    end
  end

  // Register port decode.
  assign hit_ctrl   = addr_hit(reg_addr_in, OFS_CTRL);
  assign hit_config = addr_hit(reg_addr_in, OFS_CONFIG);
  assign hit_pins   = addr_hit(reg_addr_in, OFS_PINS);
  assign hit_cells  = addr_hit(reg_addr_in, OFS_CELLS);
  assign hit_term   = (reg_addr_in >= OFS_TERM_BASE)
                      && (reg_addr_in < OFS_TERM_BASE + TERM_SPAN);
  assign term_index = reg_addr_in[5:0];
  assign wr_ctrl    = reg_wr_in & hit_ctrl;
  assign wr_config  = reg_wr_in & hit_config & prog_mode;
  assign wr_term    = reg_wr_in & hit_term & prog_mode;

  // Program mode control bit.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prog_mode <= CTRL_RESET;
    end else if (wr_ctrl) begin
      prog_mode <= reg_wdata_in[CTRL_PROG_BIT];
    end
  end

  // Control word; only the two globals and sixteen locals are stored.
  // control word storage
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      config_word <= CONFIG_RESET;
    end else if (wr_config) begin
      config_word <= reg_wdata_in & 32'h0003_FFFF;
    end
  end

  // Connection pattern of the AND array, one word per product term.
  // Reset leaves every term unconnected, which reads high.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_PTS; i++) begin
        term_fuses[i] <= TERM_RESET;
      end
    end else if (wr_term) begin
      term_fuses[term_index] <= reg_wdata_in;
    end
  end

  // Read views of live state.
  assign ctrl_view  = {31'h0000_0000, prog_mode};
  assign pins_view  = {14'h0000, oe_sync, clk_sync, in_sync, io_sync};
  assign cells_view = {8'h00, cell_data, cell_enable, cell_state};

  // Read selection; unmapped addresses read zero.
  assign read_value = hit_ctrl   ? ctrl_view              :
                      hit_config ? config_word            :
                      hit_pins   ? pins_view              :
                      hit_cells  ? cells_view             :
                      hit_term   ? term_fuses[term_index] :
                      32'h0000_0000;

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? read_value : '0;
    end
  end
endmodule // mla_array

`default_nettype wire

// ---- mla_array_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module mla_array_asserts
  import mla_pkg::*;
(
  input wire logic              clock_in,
  input wire logic              rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic              pin_clk_in,
  input wire logic              pin_oe_n_in,
  input wire logic [7:0]        pin_input_in,
  input wire logic [7:0]        io_in,
  input wire logic [7:0]        io_out,
  input wire logic [7:0]        io_oe_out
);
  logic [17:0] cfg;
  logic        prog;
  logic [3:0]  quiet;
  logic [7:0]  clk_h;
  logic [7:0]  oe_h;
  // Shadow of the control word, so that every cell's mode is known from the bus.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg   <= CONFIG_RESET[17:0];
      prog  <= 1'b0;
      quiet <= 4'h0;
      clk_h <= 8'h00;
      oe_h  <= 8'h00;
    end else begin
      if (reg_wr_in && reg_addr_in == OFS_CTRL) prog <= reg_wdata_in[CTRL_PROG_BIT];
      if (reg_wr_in && reg_addr_in == OFS_CONFIG && prog) cfg <= reg_wdata_in[17:0];
      quiet <= reg_wr_in ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      clk_h <= {clk_h[6:0], pin_clk_in};
      oe_h  <= {oe_h[6:0], pin_oe_n_in};
    end
  end
  // Mode masks; checks wait until writes and pins have been quiet long enough
  // for the synchronisers to settle, which trades a few cycles of blindness.
  wire [7:0] no_reg = {8{cfg[CFG_ALLOW_BIT] & ~cfg[CFG_EMUL_BIT]}};
  wire [7:0] m_in   = no_reg & cfg[7:0];
  wire [7:0] m_out  = no_reg & ~cfg[7:0];
  wire [7:0] m_reg  = {8{~cfg[CFG_ALLOW_BIT] & cfg[CFG_EMUL_BIT]}} & ~cfg[7:0];
  wire       calm   = quiet == 4'hF && !prog;
  wire       gap    = (reg_addr_in > OFS_CELLS && reg_addr_in < OFS_TERM_BASE) || reg_addr_in[7];
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  a_reset_idle: assert property ($rose(rst_n_in) |-> io_out == 8'h00 && io_oe_out == 8'h00)
    else $error("outputs not idle after reset");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside read cycle");
  a_cfg_readback: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFS_CONFIG |->
    reg_rdata_out == {14'h0000, $past(cfg)})
    else $error("control word readback wrong");
  a_unmapped_zero: assert property (reg_rd_in && gap |=> reg_rdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_prog_off: assert property (reg_wr_in && reg_addr_in == OFS_CTRL && reg_wdata_in[0] |->
    ##2 (io_oe_out == 8'h00) [*2])
    else $error("outputs driven in program mode");
  a_input_off: assert property (calm |-> (io_oe_out & m_in) == 8'h00)
    else $error("dedicated input drives pin");
  a_output_on: assert property (calm |-> (io_oe_out & m_out) == m_out)
    else $error("combinatorial output not driven");
  a_reg_oe: assert property (calm && (oe_h == 8'h00 || oe_h == 8'hFF) |->
    (io_oe_out & m_reg) == (oe_h[0] ? 8'h00 : m_reg))
    else $error("registered enable not from enable pin");
  a_reg_hold: assert property (calm && (clk_h == 8'h00 || clk_h == 8'hFF) |->
    $stable(io_out & m_reg))
    else $error("registered output moved without clock pin");
  c_prog: cover property (reg_wr_in && reg_addr_in == OFS_CTRL && reg_wdata_in[0]);
  c_load: cover property (calm && m_reg != 8'h00 && $rose(pin_clk_in));
  c_read: cover property (reg_rd_in && reg_addr_in == OFS_CONFIG);
endmodule // mla_array_asserts

bind mla_array mla_array_asserts i_asserts (
  .clock_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .pin_clk_in, .pin_oe_n_in, .pin_input_in, .io_in, .io_out, .io_oe_out
);
`default_nettype wire

// ---- mla_board.sv ----
`timescale 1ns/1ps
`default_nettype none

module mla_board
  import mla_pkg::*;
(
  input  wire logic                 outs_on_in,
  input  wire logic [NUM_CELLS-1:0] board_io_in,
  input  wire logic [NUM_CELLS-1:0] io_out_in,
  input  wire logic [NUM_CELLS-1:0] io_oe_in,
  output logic                      pin_oe_n_out,
  output logic      [NUM_CELLS-1:0] io_wire_out
);
  // The board pulls the enable pin low when it wants the registered pins on.
  // enable pin low
  assign pin_oe_n_out = !outs_on_in;
  // The board drives every pin the device releases, so no pin keeps the
  // device's last level once its buffer turns off.
  assign io_wire_out = (io_oe_in & io_out_in) | (~io_oe_in & board_io_in);
endmodule // mla_board
`default_nettype wire

// ---- mla_cell.sv ----
`timescale 1ns/1ps
`default_nettype none

package mla_pkg;
  localparam int          NUM_CELLS     = 8;
  localparam int          NUM_TERMS     = 8;
  localparam int          NUM_INPUTS    = 8;
  localparam int          NUM_COLS      = 32;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_CONFIG    = 8'h01;
  localparam logic [7:0]  OFS_PINS      = 8'h02;
  localparam logic [7:0]  OFS_CELLS     = 8'h03;
  localparam logic [7:0]  OFS_TERM_BASE = 8'h40;
  localparam logic [7:0]  TERM_SPAN     = 8'h40;
  localparam int          CTRL_PROG_BIT = 0;
  localparam int          CFG_LOCAL_LSB = 0;
  localparam int          CFG_POL_LSB   = 8;
  localparam int          CFG_ALLOW_BIT = 16;
  localparam int          CFG_EMUL_BIT  = 17;
  localparam int          PIN_IO_LSB    = 0;
  localparam int          PIN_IN_LSB    = 8;
  localparam int          PIN_CLK_BIT   = 16;
  localparam int          PIN_OE_BIT    = 17;
  localparam int          CELL_Q_LSB    = 0;
  localparam int          CELL_EN_LSB   = 8;
  localparam int          CELL_DATA_LSB = 16;
  localparam logic [31:0] CONFIG_RESET  = 32'h0001_00FF;
  localparam logic        CTRL_RESET    = 1'b0;
  localparam logic [31:0] TERM_RESET    = 32'h0000_0000;
  localparam logic [7:0]  MASK_ALL_TERMS = 8'hFF;
  localparam logic [7:0]  MASK_IO_TERMS  = 8'hFE;
endpackage : mla_pkg

module mla_cell
  import mla_pkg::*;
#(
  parameter bit EDGE_CELL = 1'b0
) (
  input  wire logic                 clock_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 clear_in,
  input  wire logic                 clk_rise_in,
  input  wire logic [NUM_TERMS-1:0] term_in,
  input  wire logic                 register_allow_global_in,
  input  wire logic                 emulation_select_global_in,
  input  wire logic                 cell_config_local_in,
  input  wire logic                 polarity_local_in,
  input  wire logic                 oe_pin_n_in,
  input  wire logic                 io_pin_in,
  input  wire logic                 adjacent_pin_in,
  output logic                      feedback_out,
  output logic                      data_out,
  output logic                      enable_out,
  output logic                      state_out
);
  logic q;
  logic io_mode;
  logic registered;
  logic fb_from_cell;
  logic or_sum;
  logic polar_sum;
  logic [NUM_TERMS-1:0] term_mask;

  // Mode decode from the global emulation and allow bits and the local configuration bit.
  // mode decode
  assign io_mode    = emulation_select_global_in & cell_config_local_in;
  assign registered = ~register_allow_global_in & emulation_select_global_in
                      & ~cell_config_local_in;

  // Product-term multiplexer: I/O modes lend the first term to the enable.
  // term steering
  assign term_mask = io_mode ? MASK_IO_TERMS : MASK_ALL_TERMS;
  assign or_sum    = |(term_in & term_mask);
  assign polar_sum = or_sum ^ ~polarity_local_in;

  // The flop holds the inverse, so a cleared flop drives the pin high.
  // clocked register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= 1'b0;
    end else if (clear_in) begin
      q <= 1'b0;
    end else if (clk_rise_in && registered) begin
      q <= ~polar_sum;
    end
  end

  // Output select multiplexer.
  // output select
  assign data_out = registered ? ~q : polar_sum;

  // Enable select multiplexer: pin, product term, always on or always off.
  // enable select
  assign enable_out = registered ? ~oe_pin_n_in :
                      io_mode    ? term_in[0]   :
                      ~cell_config_local_in;

  // Feedback multiplexer; edge cells steer it by the inverted allow bit.
  // edge feedback control
  assign fb_from_cell = EDGE_CELL ? ~register_allow_global_in : emulation_select_global_in;
  assign feedback_out = fb_from_cell ? (cell_config_local_in ? io_pin_in : ~q)
                                     : adjacent_pin_in;
  assign state_out    = q;
endmodule // mla_cell

`default_nettype wire
